// ---- ufl_serial_core.sv ----
// Summary of operation
// - Byte into full rx FIFO sets overflow flag
// - Reading empty rx FIFO sets underflow flag
// - Writing 0 clears overflow/underflow flag and enable
// - FIFO reset clears overflow and underflow flags
// - Missing stop bit sets framing error flag
// - Framing error held until 0 written; not reset
// - Tx complete when all sent and FIFO empty
// - Clearing a flag also disables its interrupt
// - Data read returns and pops oldest rx byte
// - Data write pushes byte into tx FIFO
// - LIN mode leaves all ordinary functions working
// - Tx ready flag high while level below threshold
// - Divisor zero with unit disabled resets FIFOs
`timescale 1ns/1ps
`default_nettype none
module ufl_serial_core (
  // Clock and reset
  input  wire logic                       core_clk,
  input  wire logic                       rst_b,
  // APB slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [ufl_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                pwdata,
  output logic                            pready,
  output logic      [31:0]                prdata,
  output logic                            pslverr,
  // Receive shifter side
  input  wire logic                       rx_byte_valid,
  input  wire logic [7:0]                 rx_byte,
  input  wire logic                       rx_stop_ok,
  // Transmit shifter side
  output logic                            tx_byte_valid,
  output logic      [7:0]                 tx_byte,
  input  wire logic                       tx_byte_taken,
  input  wire logic                       tx_line_idle,
  // Interrupt and LIN side
  output logic                            irq,
  output logic                            lin_counter_clear
);

  function automatic logic reg_hit(input logic [ufl_pkg::ADDR_W-1:0] a, input logic [7:0] idx);
    reg_hit = (a == {2'b00, idx, 2'b00});
  endfunction : reg_hit

  logic [7:0]                 rx_mem [ufl_pkg::FIFO_DEPTH];
  logic [7:0]                 tx_mem [ufl_pkg::FIFO_DEPTH];
  logic [ufl_pkg::PTR_W-1:0]  rx_wp_r, rx_wp_nxt, rx_rp_r, rx_rp_nxt;
  logic [ufl_pkg::PTR_W-1:0]  tx_wp_r, tx_wp_nxt, tx_rp_r, tx_rp_nxt;
  logic [ufl_pkg::CNT_W-1:0]  rx_cnt_r, rx_cnt_nxt, tx_cnt_r, tx_cnt_nxt;
  ufl_pkg::ufl_irq_bits_t     flags_r, flags_nxt, en_r, en_nxt;
  logic [11:0]                baud_divisor_r, baud_divisor_nxt;
  logic                       serial_unit_enable_r, serial_unit_enable_nxt;
  logic [3:0]                 tx_thr_r, tx_thr_nxt;
  logic                       pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  logic [31:0]                prdata_r, prdata_nxt;
  logic                       rd_pop_r, rd_pop_nxt;
  logic                       tx_valid_r, tx_valid_nxt, tx_sent_r, tx_sent_nxt;
  logic [7:0]                 tx_data_r, tx_data_nxt;
  logic                       irq_r, irq_nxt, lin_clr_r, lin_clr_nxt;

  logic setup, acc, wr_acc, rd_acc;
  logic hit_data, hit_int, hit_ctrl, hit_stat, mapped;
  logic data_wr, data_rd, rx_pop, rx_push, rx_ovf, rx_unf, tx_push, tx_ld, fifo_rst, int_wr;
  logic [7:0] fl_v, en_v;

  always_comb begin
    setup    = psel && !penable;
    acc      = psel && penable && pready_r;
    wr_acc   = acc && pwrite;
    rd_acc   = acc && !pwrite;
    hit_data = reg_hit(paddr, ufl_pkg::DATA_IDX);
    hit_int  = reg_hit(paddr, ufl_pkg::INT_IDX);
    hit_ctrl = reg_hit(paddr, ufl_pkg::CTRL_IDX);
    hit_stat = reg_hit(paddr, ufl_pkg::STAT_IDX);
    mapped   = hit_data || hit_int || hit_ctrl || hit_stat;
    int_wr   = wr_acc && hit_int;
    data_wr  = wr_acc && hit_data;
    data_rd  = rd_acc && hit_data;
    // Divisor zero with unit disabled empties both FIFOs
    fifo_rst = wr_acc && hit_ctrl && (pwdata[ufl_pkg::BAUD_LSB +: ufl_pkg::BAUD_W] == 12'h000)
               && !pwdata[ufl_pkg::UEN_BIT];
    rx_pop   = data_rd && rd_pop_r;
    rx_unf   = data_rd && !rd_pop_r;
    rx_ovf   = rx_byte_valid && (rx_cnt_r == ufl_pkg::FIFO_FULL);
    rx_push  = rx_byte_valid && !rx_ovf;
    tx_push  = data_wr && (tx_cnt_r != ufl_pkg::FIFO_FULL);
    tx_ld    = (tx_cnt_r != 5'h00) && (!tx_valid_r || tx_byte_taken);

    // APB: zero wait states, answer prepared during setup
    pready_nxt  = setup;
    pslverr_nxt = setup && !mapped;
    rd_pop_nxt  = setup && !pwrite && hit_data && (rx_cnt_r != 5'h00);
    prdata_nxt  = 32'h0000_0000;
    if (setup && !pwrite) begin
      if (hit_data && rx_cnt_r != 5'h00) begin
        prdata_nxt = {24'h000000, rx_mem[rx_rp_r]};
      end else if (hit_int) begin
        prdata_nxt = {24'h000000, flags_r};
      end else if (hit_ctrl) begin
        prdata_nxt = {12'h000, tx_thr_r, 3'h0, serial_unit_enable_r, baud_divisor_r};
      end else if (hit_stat) begin
        prdata_nxt = {11'h000, tx_cnt_r, 3'h0, rx_cnt_r, en_r};
      end
    end

    // Control register; ordinary paths ignore any LIN mode
    baud_divisor_nxt       = baud_divisor_r;
    serial_unit_enable_nxt = serial_unit_enable_r;
    tx_thr_nxt             = tx_thr_r;
    if (wr_acc && hit_ctrl) begin
      baud_divisor_nxt       = pwdata[ufl_pkg::BAUD_LSB +: ufl_pkg::BAUD_W];
      serial_unit_enable_nxt = pwdata[ufl_pkg::UEN_BIT];
      tx_thr_nxt             = pwdata[ufl_pkg::THR_LSB +: ufl_pkg::THR_W];
    end
    lin_clr_nxt = fifo_rst;

    // Receive FIFO pointers
    rx_wp_nxt  = rx_wp_r + PTR1(rx_push);
    rx_rp_nxt  = rx_rp_r + PTR1(rx_pop);
    rx_cnt_nxt = rx_cnt_r + CNT1(rx_push) - CNT1(rx_pop);
    if (fifo_rst) begin
      rx_wp_nxt  = '0;
      rx_rp_nxt  = '0;
      rx_cnt_nxt = '0;
    end

    // Transmit FIFO pointers and output stage
    tx_wp_nxt    = tx_wp_r + PTR1(tx_push);
    tx_rp_nxt    = tx_rp_r + PTR1(tx_ld);
    tx_cnt_nxt   = tx_cnt_r + CNT1(tx_push) - CNT1(tx_ld);
    tx_valid_nxt = tx_ld ? 1'b1 : (tx_valid_r && !tx_byte_taken);
    tx_data_nxt  = tx_ld ? tx_mem[tx_rp_r] : tx_data_r;
    if (fifo_rst) begin
      tx_wp_nxt  = '0;
      tx_rp_nxt  = '0;
      tx_cnt_nxt = '0;
    end

    // Interrupt flags: clear first, then events, so a set wins
    fl_v = flags_r;
    en_v = en_r;
    if (int_wr) begin
      en_v = (en_v & ~ufl_pkg::EN_MASK) | (pwdata[7:0] & ufl_pkg::EN_MASK);
      fl_v = fl_v & ~(~pwdata[7:0] & ufl_pkg::CLR_MASK);
    end
    flags_nxt = fl_v;
    en_nxt    = en_v;
    if (fifo_rst) begin
      flags_nxt.rx_overflow_flag  = 1'b0;
      flags_nxt.rx_underflow_flag = 1'b0;
    end
    if (rx_ovf) begin
      flags_nxt.rx_overflow_flag = 1'b1;
    end
    if (rx_unf) begin
      flags_nxt.rx_underflow_flag = 1'b1;
    end
    if (rx_byte_valid && !rx_stop_ok) begin
      flags_nxt.framing_error_flag = 1'b1;
    end
    tx_sent_nxt = (tx_sent_r || tx_push) && !fifo_rst;
    if (tx_sent_r && tx_cnt_r == 5'h00 && !tx_valid_r && tx_line_idle) begin
      flags_nxt.tx_complete_flag = 1'b1;
      tx_sent_nxt                = tx_push;
    end
    flags_nxt.tx_ready_flag = ({1'b0, tx_thr_r} > tx_cnt_nxt);
    flags_nxt.global_en     = 1'b0;
    flags_nxt.rsv5          = 1'b0;
    flags_nxt.rsv2          = 1'b0;
    irq_nxt = en_nxt.global_en && ((flags_nxt & en_nxt & ufl_pkg::SRC_MASK) != 8'h00);
  end

  function automatic logic [ufl_pkg::PTR_W-1:0] PTR1(input logic b);
    PTR1 = {{(ufl_pkg::PTR_W-1){1'b0}}, b};
  endfunction : PTR1

  function automatic logic [ufl_pkg::CNT_W-1:0] CNT1(input logic b);
    CNT1 = {{(ufl_pkg::CNT_W-1){1'b0}}, b};
  endfunction : CNT1

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_wp_r              <= '0;
      rx_rp_r              <= '0;
      rx_cnt_r             <= '0;
      tx_wp_r              <= '0;
      tx_rp_r              <= '0;
      tx_cnt_r             <= '0;
      flags_r              <= ufl_pkg::IRQ_RST;
      en_r                 <= ufl_pkg::IRQ_RST;
      baud_divisor_r       <= ufl_pkg::BAUD_RST;
      serial_unit_enable_r <= 1'b0;
      tx_thr_r             <= ufl_pkg::THR_RST;
      pready_r             <= 1'b0;
      pslverr_r            <= 1'b0;
      prdata_r             <= 32'h0000_0000;
      rd_pop_r             <= 1'b0;
      tx_valid_r           <= 1'b0;
      tx_data_r            <= ufl_pkg::DATA_RST;
      tx_sent_r            <= 1'b0;
      irq_r                <= 1'b0;
      lin_clr_r            <= 1'b0;
    end else begin
      rx_wp_r              <= rx_wp_nxt;
      rx_rp_r              <= rx_rp_nxt;
      rx_cnt_r             <= rx_cnt_nxt;
      tx_wp_r              <= tx_wp_nxt;
      tx_rp_r              <= tx_rp_nxt;
      tx_cnt_r             <= tx_cnt_nxt;
      flags_r              <= flags_nxt;
      en_r                 <= en_nxt;
      baud_divisor_r       <= baud_divisor_nxt;
      serial_unit_enable_r <= serial_unit_enable_nxt;
      tx_thr_r             <= tx_thr_nxt;
      pready_r             <= pready_nxt;
      pslverr_r            <= pslverr_nxt;
      prdata_r             <= prdata_nxt;
      rd_pop_r             <= rd_pop_nxt;
      tx_valid_r           <= tx_valid_nxt;
      tx_data_r            <= tx_data_nxt;
      tx_sent_r            <= tx_sent_nxt;
      irq_r                <= irq_nxt;
      lin_clr_r            <= lin_clr_nxt;
    end
  end

  // FIFO storage, no reset needed
  always_ff @(posedge core_clk) begin
    if (rx_push) begin
      rx_mem[rx_wp_r] <= rx_byte;
    end
    if (tx_push) begin
      tx_mem[tx_wp_r] <= pwdata[7:0];
    end
  end

  always_comb begin
    pready            = pready_r;
    pslverr           = pslverr_r;
    prdata            = prdata_r;
    tx_byte_valid     = tx_valid_r;
    tx_byte           = tx_data_r;
    irq               = irq_r;
    lin_counter_clear = lin_clr_r;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  sequence s_empty_read;
    psel && penable && pready_r && !pwrite && hit_data && !rd_pop_r;
  endsequence

  sequence s_tx_drained;
    tx_sent_r && tx_cnt_r == 5'h00 && !tx_valid_r && tx_line_idle;
  endsequence

  a_ovf_flag_set: assert property (rx_byte_valid && rx_cnt_r == 5'h10 |=> flags_r.rx_overflow_flag)
    else $error("overflow flag not set");
  a_unf_flag_set: assert property (s_empty_read |=> flags_r.rx_underflow_flag)
    else $error("underflow flag not set");
  a_ovf_zero_clear: assert property (int_wr && !pwdata[4] && !rx_ovf
    |=> !flags_r.rx_overflow_flag && !en_r.rx_overflow_flag)
    else $error("overflow clear did not drop flag and enable");
  a_fifo_reset_clear: assert property (fifo_rst && !rx_byte_valid && !rx_unf
    |=> rx_cnt_r == 5'h00 && tx_cnt_r == 5'h00 && !flags_r.rx_overflow_flag && lin_counter_clear)
    else $error("fifo reset incomplete");
  a_framing_error_flag_flag_set: assert property (rx_byte_valid && !rx_stop_ok |=> flags_r.framing_error_flag)
    else $error("framing error flag not set");
  a_framing_error_flag_flag_hold: assert property (flags_r.framing_error_flag && !(int_wr && !pwdata[1])
    |=> flags_r.framing_error_flag)
    else $error("framing error flag lost");
  a_txc_flag_set: assert property (s_tx_drained |=> flags_r.tx_complete_flag)
    else $error("tx complete flag not set");
  a_txc_en_clear: assert property (int_wr && !pwdata[0] |=> !en_r.tx_complete_flag
    && (!irq_r || (en_r.global_en && ((flags_r & en_r & ufl_pkg::SRC_MASK) != 8'h00))))
    else $error("tx complete enable not cleared");
  a_rx_pop_count: assert property (rx_pop && !rx_push && !fifo_rst |=> rx_cnt_r == $past(rx_cnt_r) - 5'h01)
    else $error("rx read did not pop");
  a_tx_push_count: assert property (tx_push && !tx_ld && !fifo_rst |=> tx_cnt_r == $past(tx_cnt_r) + 5'h01)
    else $error("tx write did not push");
  a_trdy_level: assert property (rst_b |=> flags_r.tx_ready_flag == ({1'b0, tx_thr_r} > tx_cnt_r)
    || $changed(tx_thr_r))
    else $error("tx ready flag wrong");
  a_empty_read_ptr: assert property ((s_empty_read and !fifo_rst) |-> prdata_r == 32'h0
    ##1 rx_rp_r == $past(rx_rp_r))
    else $error("empty read moved pointer");

endmodule : ufl_serial_core
`default_nettype wire

// ---- ufl_pkg.sv ----
`default_nettype none
package ufl_pkg;
  // APB decode: printed offsets are register indexes, byte address is index * 4
  localparam int          ADDR_W     = 12;
  localparam logic [7:0]  DATA_IDX   = 8'ha6;
  localparam logic [7:0]  INT_IDX    = 8'ha7;
  localparam logic [7:0]  CTRL_IDX   = 8'ha8;
  localparam logic [7:0]  STAT_IDX   = 8'ha9;

  // FIFO geometry
  localparam int          FIFO_DEPTH = 16;
  localparam int          PTR_W      = 4;
  localparam int          CNT_W      = 5;
  localparam logic [4:0]  FIFO_FULL  = 5'h10;

  // Control register layout
  localparam int          BAUD_LSB   = 0;
  localparam int          BAUD_W     = 12;
  localparam int          UEN_BIT    = 12;
  localparam int          THR_LSB    = 16;
  localparam int          THR_W      = 4;
  localparam logic [11:0] BAUD_RST   = 12'h000;
  localparam logic [3:0]  THR_RST    = 4'h1;
  localparam logic [7:0]  DATA_RST   = 8'h00;

  // Status register layout
  localparam int          STAT_RXC_LSB = 8;
  localparam int          STAT_TXC_LSB = 16;

  // Interrupt register bit masks
  localparam logic [7:0]  EN_MASK    = 8'hdb;
  localparam logic [7:0]  CLR_MASK   = 8'h1b;
  localparam logic [7:0]  SRC_MASK   = 8'h5b;

  // Interrupt register: flags on read, enables on write
  typedef struct packed {
    logic global_en;
    logic tx_ready_flag;
    logic rsv5;
    logic rx_overflow_flag;
    logic rx_underflow_flag;
    logic rsv2;
    logic framing_error_flag;
    logic tx_complete_flag;
  } ufl_irq_bits_t;

  localparam ufl_irq_bits_t IRQ_RST = '0;
endpackage : ufl_pkg
`default_nettype wire

// ---- ufl_line_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module ufl_line_model (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  // Receive shifter
  output var  logic       rx_byte_valid,
  output var  logic [7:0] rx_byte,
  output var  logic       rx_stop_ok,
  // Transmit shifter
  input  wire logic       tx_byte_valid,
  input  wire logic [7:0] tx_byte,
  output var  logic       tx_byte_taken,
  output logic            tx_line_idle
);
  logic [2:0] busy_r;

  initial begin
    rx_byte_valid = 1'b0;
    rx_byte       = 8'h00;
    rx_stop_ok    = 1'b1;
  end

  // One byte; line shows garbage between bytes
  task automatic send_byte(input logic [7:0] b, input logic ok);
    @(posedge core_clk);
    rx_byte_valid <= 1'b1;
    rx_byte       <= b;
    rx_stop_ok    <= ok;
    @(posedge core_clk);
    rx_byte_valid <= 1'b0;
    rx_byte       <= ~b;
    rx_stop_ok    <= ~ok;
  endtask : send_byte

  // Shifter takes a byte, then stays busy a random while
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_byte_taken <= 1'b0;
      busy_r        <= 3'h0;
    end else begin
      tx_byte_taken <= 1'b0;
      if (busy_r != 3'h0) begin
        busy_r <= busy_r - 3'h1;
      end else if (tx_byte_valid && !tx_byte_taken) begin
        tx_byte_taken <= 1'b1;
        busy_r        <= 3'($urandom_range(6, 2));
      end
    end
  end

  assign tx_line_idle = (busy_r == 3'h0) && !tx_byte_taken;
endmodule : ufl_line_model
`default_nettype wire

// ---- tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic                       core_clk, rst_b, psel, penable, pwrite, pready, pslverr, irq;
  logic [ufl_pkg::ADDR_W-1:0] paddr;
  logic [31:0]                pwdata, prdata;
  logic                       rx_byte_valid, rx_stop_ok, tx_byte_valid, tx_byte_taken, tx_line_idle, lin_counter_clear;
  logic [7:0]                 rx_byte, tx_byte;
  int                         failures, comparisons, clr_pulses;
  logic [64:0]                rd_q[$];
  logic [64:0]                e;
  logic [7:0]                 tx_q[$];
  logic [7:0]                 rxb[17];

  ufl_serial_core u_dut (.core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte), .rx_stop_ok(rx_stop_ok), .tx_byte_valid(tx_byte_valid),
    .tx_byte(tx_byte), .tx_byte_taken(tx_byte_taken), .tx_line_idle(tx_line_idle), .irq(irq),
    .lin_counter_clear(lin_counter_clear));

  ufl_line_model u_line (.core_clk(core_clk), .rst_b(rst_b), .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte),
    .rx_stop_ok(rx_stop_ok), .tx_byte_valid(tx_byte_valid), .tx_byte(tx_byte), .tx_byte_taken(tx_byte_taken),
    .tx_line_idle(tx_line_idle));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic complete_run;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run

  // One APB transfer, then one idle cycle
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd, input logic [64:0] ex);
    if (!wr) rd_q.push_back(ex);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    // Wait for the slave; only the watchdog ends a hang
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d, '0);
  endtask : wr

  task automatic rd(input logic [7:0] idx, input logic [31:0] v, input logic [31:0] m = 32'hffffffff,
                    input logic err = 1'b0);
    apb(1'b0, idx, 32'h0, {err, m, v});
  endtask : rd

  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask : idle

  always @(posedge core_clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && rd_q.size() > 0) begin
      e = rd_q.pop_front();
      chk(prdata & e[63:32], e[31:0] & e[63:32]);
      chk({31'h0, pslverr}, {31'h0, e[64]});
    end
    if (tx_byte_valid === 1'b1 && tx_byte_taken === 1'b1 && tx_q.size() > 0) begin
      chk({24'h0, tx_byte}, {24'h0, tx_q.pop_front()});
    end
    if (lin_counter_clear === 1'b1) clr_pulses++;
  end

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    failures++;
    complete_run();
  end

  initial begin
    int n;
    {rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
    failures = 0;
    comparisons = 0;
    clr_pulses = 0;
    void'($urandom(32'h9ad2));
    repeat (4) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    // Reset state, empty read, unmapped place
    rd(ufl_pkg::STAT_IDX, 32'h0);
    rd(ufl_pkg::INT_IDX, 32'h40);
    rd(ufl_pkg::DATA_IDX, 32'h0);
    rd(ufl_pkg::INT_IDX, 32'h48);
    rd(8'hb0, 32'h0, 32'hffffffff, 1'b1);
    wr(ufl_pkg::INT_IDX, 32'h88);
    idle(2);
    chk({31'h0, irq}, 32'h1);
    wr(ufl_pkg::INT_IDX, 32'h80);
    rd(ufl_pkg::INT_IDX, 32'h40);
    rd(ufl_pkg::STAT_IDX, 32'h80, 32'hff);
    $display("test reset done");
    // Fill past full, one bad stop bit
    wr(ufl_pkg::INT_IDX, 32'h92);
    for (int i = 0; i < 17; i++) begin
      rxb[i] = 8'($urandom);
      u_line.send_byte(rxb[i], i != 5);
    end
    idle(3);
    chk({31'h0, irq}, 32'h1);
    rd(ufl_pkg::DATA_IDX, {24'h0, rxb[0]});
    rd(ufl_pkg::DATA_IDX, {24'h0, rxb[1]});
    rd(ufl_pkg::INT_IDX, 32'h52);
    wr(ufl_pkg::CTRL_IDX, 32'h0001_0000);
    idle(2);
    chk(32'(clr_pulses), 32'h1);
    rd(ufl_pkg::INT_IDX, 32'h42);
    rd(ufl_pkg::DATA_IDX, 32'h0);
    rd(ufl_pkg::INT_IDX, 32'h4a);
    u_line.send_byte(8'h5a, 1'b1);
    idle(2);
    rd(ufl_pkg::DATA_IDX, 32'h5a);
    wr(ufl_pkg::INT_IDX, 32'h80);
    rd(ufl_pkg::INT_IDX, 32'h40);
    rd(ufl_pkg::STAT_IDX, 32'h80, 32'hff);
    idle(2);
    chk({31'h0, irq}, 32'h0);
    $display("test rx done");
    // Transmit burst until complete
    wr(ufl_pkg::INT_IDX, 32'h81);
    for (int i = 0; i < 3; i++) begin
      rxb[i] = 8'($urandom);
      tx_q.push_back(rxb[i]);
      wr(ufl_pkg::DATA_IDX, {24'h0, rxb[i]});
    end
    n = 0;
    while ((tx_q.size() > 0 || irq !== 1'b1) && n < 500) begin
      @(posedge core_clk);
      n++;
    end
    chk({31'h0, irq}, 32'h1);
    rd(ufl_pkg::INT_IDX, 32'h1, 32'h1);
    wr(ufl_pkg::INT_IDX, 32'h0);
    rd(ufl_pkg::INT_IDX, 32'h0, 32'h1);
    idle(2);
    chk({31'h0, irq}, 32'h0);
    $display("test tx done");
    complete_run();
  end
endmodule : tb
`default_nettype wire
